// File: verilog/qos_meter_pkg.sv
// Purpose: Shared constants and types for the token bucket traffic meter.
// Assumes: One 25 MHz clock, AXI4-Lite register access with byte addresses.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package qos_meter_pkg;
    localparam int ADDR_W = 8;
    localparam int LEN_W = 16;
    localparam int TOK_W = 24;
    localparam int CLK_MHZ = 25;
    localparam int RATE_WINDOW_US = 1000000;
    localparam int RATE_WINDOW_CYC = RATE_WINDOW_US * CLK_MHZ;
    localparam int NUM_WAN = 2;
    localparam int NUM_QUEUE = 4;
    localparam int NUM_KEY = NUM_WAN + NUM_QUEUE;
    localparam int NUM_STAT = 2 * NUM_KEY;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] BUCKET_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] FILL_PERIOD_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] FILL_AMOUNT_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] MARKS_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] TOKENS_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] STAT_BASE_OFS = 8'h20;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_POLICE_BIT = 1;
    localparam int CTRL_RED_MARK_BIT = 2;
    localparam int CTRL_GREEN_MARK_BIT = 3;
    localparam int MARKS_GREEN_LSB = 0;
    localparam int MARKS_RED_LSB = 8;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [TOK_W-1:0] BUCKET_RST = 24'h002800;
    localparam logic [15:0] FILL_PERIOD_RST = 16'h0014;
    localparam logic [15:0] FILL_AMOUNT_RST = 16'h0001;
    localparam logic [5:0] DSCP_MARK_RST = 6'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        best_effort, background, spare, excellent, controlled, video, voice, net_control
    } traffic_e;

    typedef struct packed {
        logic [LEN_W-1:0] length;
        logic [1:0] queue;
        logic wan;
        logic [15:0] tci;
        logic [7:0] tos;
    } pkt_s;

    typedef struct packed {
        pkt_s pkt;
        traffic_e traffic;
        logic [11:0] vlan_id;
        logic [2:0] precedence;
        logic [5:0] dscp;
        logic red;
    } out_s;
endpackage

// File: verilog/two_entry_buffer.sv
// Purpose: Two-entry valid/ready buffer with registered outputs.
// Assumes: Same clock on both sides.
// Notes: Ready to the source is low only when both entries hold data.
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int WIDTH = 8
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic in_valid, // Source offers a word
    output logic in_ready, // Buffer can take a word
    input wire logic [WIDTH-1:0] in_data, // Word from source
    output logic out_valid, // Head holds a word
    input wire logic out_ready, // Sink takes the head
    output logic [WIDTH-1:0] out_data // Head word
);
    logic [WIDTH-1:0] tail;
    logic tail_valid;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid <= 1'b0;
            tail_valid <= 1'b0;
            in_ready <= 1'b1;
        end else begin
            if (pop) begin
                out_valid <= tail_valid || push;
                tail_valid <= tail_valid && push;
                in_ready <= 1'b1;
            end else if (push) begin
                out_valid <= 1'b1;
                tail_valid <= out_valid;
                in_ready <= !out_valid;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (pop) begin
            out_data <= tail_valid ? tail : in_data;
        end else if (push && !out_valid) begin
            out_data <= in_data;
        end
        if (push && out_valid && !(pop && !tail_valid)) begin
            tail <= in_data;
        end
    end
endmodule

// File: verilog/rate_counter.sv
// Purpose: Counts event pulses over a window and holds the last total.
// Assumes: Window tick is a one-cycle pulse from a shared divider.
// Notes: Count saturates so a long window never wraps.
`timescale 1ns/1ps
module rate_counter #(
    parameter int CNT_W = 32
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic event_pulse, // One event this cycle
    input wire logic window_tick, // End of measuring window
    output logic [CNT_W-1:0] rate // Events in last window
);
    logic [CNT_W-1:0] count;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            rate <= '0;
        end else if (window_tick) begin
            rate <= count + CNT_W'(event_pulse);
            count <= '0;
        end else if (event_pulse && (count != '1)) begin
            count <= count + 1'b1;
        end
    end
endmodule

// File: verilog/token_bucket_traffic_meter.sv
// Purpose: Token bucket meter with priority parsing and pass/drop rates.
// Assumes: Descriptors come from queue logic on the same clock.
// Notes: One descriptor is judged at a time; shaping back-pressures input.
// Function
// [RULE1] Extract 12-bit VLAN id and 3-bit priority
// [RULE2] Priority selects one of eight traffic types
// [RULE3] Service octet upper six bits are DSCP
// [RULE4] DSCP keeps old precedence bits compatible
// [RULE5] Precedence is top three service bits
// [RULE6] One token per byte, capped at size
// [RULE7] Constant fill rate, saturating at size
// [RULE8] Send only when tokens cover length
// [RULE9] Subtract packet length after sending
// [RULE10] Empty bucket stops sending until refilled
// [RULE11] Shaping holds packet until tokens suffice
// [RULE12] Policing drops or red-marks short packets
// [RULE13] Per-WAN pass and drop rates
// [RULE14] Per-queue pass and drop rates
// [RULE15] Software keeps bucket within interface bandwidth
// [RULE16] Committed burst not above second bucket
// [RULE17] Conforming packets pass or get green mark
// [RULE18] Reset or enable fills bucket completely
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module token_bucket_traffic_meter
    import qos_meter_pkg::*;
#(
    parameter int RATE_WINDOW = RATE_WINDOW_CYC
) (
    input wire logic aclk, // Clock, 25 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic in_valid, // Descriptor offered
    output logic in_ready, // Descriptor taken
    input wire pkt_s in_pkt, // Descriptor from queues
    output logic out_valid, // Descriptor to egress
    input wire logic out_ready, // Egress takes descriptor
    output out_s out_pkt, // Parsed, marked descriptor
    output logic drop_pulse // Packet discarded in the previous cycle
);
    typedef enum logic {SLOT_EMPTY, SLOT_FULL} slot_e;

    // ----------------------------------------
    // Configuration and bus state
    // ----------------------------------------
    logic [3:0] ctrl, wr_strb;
    logic [TOK_W-1:0] bucket_size;
    logic [15:0] fill_period, fill_amount;
    logic [5:0] green_dscp, red_dscp;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data, rd_word, cur_word, new_word;
    logic wr_fire, rd_hit;

    // ----------------------------------------
    // Meter state
    // ----------------------------------------
    slot_e state;
    pkt_s slot;
    logic [TOK_W-1:0] tokens, next_tokens, tok_minus_len;
    logic [TOK_W+1:0] tok_sum;
    logic [15:0] fill_cnt;
    logic [31:0] win_cnt;
    logic en_q, enable_rise, fill_tick, win_tick, fits, send, drop, consume;
    logic mark_red, buf_ready, pass_evt;
    out_s buf_word;
    logic [NUM_KEY-1:0] key_hit;
    logic [NUM_STAT-1:0] stat_evt;
    logic [31:0] stat_rate [NUM_STAT];

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    // Address and data may arrive in either order; ready drops once each is held
    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_addr <= MARKS_OFS && wr_addr[1:0] == 2'h0) ? RESP_OKAY
                                                                              : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Unwritten byte lanes keep the field's present bits
    always_comb begin
        unique case (wr_addr)
            CTRL_OFS: cur_word = {28'h0, ctrl};
            BUCKET_OFS: cur_word = {8'h0, bucket_size};
            FILL_PERIOD_OFS: cur_word = {16'h0, fill_period};
            FILL_AMOUNT_OFS: cur_word = {16'h0, fill_amount};
            MARKS_OFS: cur_word = {18'h0, red_dscp, 2'h0, green_dscp};
            default: cur_word = 32'h0;
        endcase
        for (int i = 0; i < 4; i++) begin
            new_word[8*i +: 8] = wr_strb[i] ? wr_data[8*i +: 8] : cur_word[8*i +: 8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RST;
            bucket_size <= BUCKET_RST;
            fill_period <= FILL_PERIOD_RST;
            fill_amount <= FILL_AMOUNT_RST;
            green_dscp <= DSCP_MARK_RST;
            red_dscp <= DSCP_MARK_RST;
        end else if (wr_fire) begin
            unique case (wr_addr)
                CTRL_OFS: ctrl <= new_word[3:0];
                BUCKET_OFS: bucket_size <= new_word[TOK_W-1:0];
                FILL_PERIOD_OFS: fill_period <= new_word[15:0];
                FILL_AMOUNT_OFS: fill_amount <= new_word[15:0];
                MARKS_OFS: begin
                    green_dscp <= new_word[MARKS_GREEN_LSB +: 6];
                    red_dscp <= new_word[MARKS_RED_LSB +: 6];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    always_comb begin
        rd_word = 32'h0;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            CTRL_OFS: rd_word = {28'h0, ctrl};
            BUCKET_OFS: rd_word = {8'h0, bucket_size};
            FILL_PERIOD_OFS: rd_word = {16'h0, fill_period};
            FILL_AMOUNT_OFS: rd_word = {16'h0, fill_amount};
            MARKS_OFS: rd_word = {18'h0, red_dscp, 2'h0, green_dscp};
            TOKENS_OFS: rd_word = {8'h0, tokens};
            STATUS_OFS: rd_word = {30'h0, out_valid, state == SLOT_FULL};
            default: begin
                rd_hit = 1'b0;
                for (int i = 0; i < NUM_STAT; i++) begin
                    if (s_axi_araddr == STAT_BASE_OFS + ADDR_W'(4 * i)) begin
                        rd_word = stat_rate[i];
                        rd_hit = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // Dividers
    // ----------------------------------------
    // Period zero behaves as one so the bucket still fills
    assign fill_tick = (17'(fill_cnt) + 17'h1) >= 17'(fill_period);
    assign win_tick = win_cnt == 32'(RATE_WINDOW - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn || fill_tick) begin
            fill_cnt <= 16'h0;
        end else begin
            fill_cnt <= fill_cnt + 16'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || win_tick) begin
            win_cnt <= 32'h0;
        end else begin
            win_cnt <= win_cnt + 32'h1;
        end
    end

    // ----------------------------------------
    // Descriptor slot and judgement
    // ----------------------------------------
    assign fits = tokens >= TOK_W'(slot.length); // RULE8
    assign mark_red = ctrl[CTRL_EN_BIT] && !fits && ctrl[CTRL_RED_MARK_BIT];
    always_comb begin
        send = 1'b0;
        drop = 1'b0;
        if (state == SLOT_FULL) begin
            if (!ctrl[CTRL_EN_BIT] || fits) begin
                send = 1'b1;
            end else if (ctrl[CTRL_POLICE_BIT]) begin
                send = ctrl[CTRL_RED_MARK_BIT]; // RULE12
                drop = !ctrl[CTRL_RED_MARK_BIT]; // RULE12
            end
        end
    end
    // Shaping with too few tokens leaves send and drop low: the slot waits
    assign pass_evt = send && buf_ready;
    assign consume = pass_evt && ctrl[CTRL_EN_BIT] && fits; // RULE9

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= SLOT_EMPTY;
            in_ready <= 1'b1;
            drop_pulse <= 1'b0;
        end else begin
            drop_pulse <= drop;
            unique case (state)
                SLOT_EMPTY: if (in_valid) begin
                    state <= SLOT_FULL;
                    in_ready <= 1'b0;
                end
                SLOT_FULL: if (pass_evt || drop) begin // RULE10 RULE11
                    state <= SLOT_EMPTY;
                    in_ready <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (in_valid && in_ready) begin
            slot <= in_pkt;
        end
    end

    // ----------------------------------------
    // Priority parsing and marking
    // ----------------------------------------
    always_comb begin
        buf_word.pkt = slot;
        buf_word.vlan_id = slot.tci[11:0]; // RULE1
        buf_word.traffic = traffic_e'(slot.tci[15:13]); // RULE1 RULE2
        buf_word.dscp = slot.tos[7:2]; // RULE3
        buf_word.red = mark_red;
        if (mark_red) begin
            buf_word.dscp = red_dscp; // RULE12
        end else if (ctrl[CTRL_EN_BIT] && ctrl[CTRL_GREEN_MARK_BIT]) begin
            buf_word.dscp = green_dscp; // RULE17
        end
        // Precedence follows the outgoing octet, so older gear sees the mark
        buf_word.precedence = buf_word.dscp[5:3]; // RULE4 RULE5
        buf_word.pkt.tos = {buf_word.dscp, slot.tos[1:0]};
    end

    two_entry_buffer #(.WIDTH($bits(out_s))) egress_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(send),
        .in_ready(buf_ready),
        .in_data(buf_word),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_pkt)
    );

    // ----------------------------------------
    // Token bucket
    // ----------------------------------------
    assign enable_rise = ctrl[CTRL_EN_BIT] && !en_q;
    assign tok_minus_len = tokens - TOK_W'(slot.length);

    always_comb begin
        tok_sum = (TOK_W+2)'(tokens) + (fill_tick ? (TOK_W+2)'(fill_amount) : '0); // RULE7
        if (consume) begin
            tok_sum = tok_sum - (TOK_W+2)'(slot.length); // RULE9
        end
        // Clamp also covers software shrinking the bucket below the count
        next_tokens = (tok_sum > (TOK_W+2)'(bucket_size)) ? bucket_size
                                                           : tok_sum[TOK_W-1:0]; // RULE6
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tokens <= BUCKET_RST; // RULE18
            en_q <= 1'b0;
        end else begin
            en_q <= ctrl[CTRL_EN_BIT];
            tokens <= enable_rise ? bucket_size : next_tokens; // RULE18
        end
    end

    // ----------------------------------------
    // Pass and drop rate statistics
    // ----------------------------------------
    always_comb begin
        for (int k = 0; k < NUM_KEY; k++) begin
            key_hit[k] = (k < NUM_WAN) ? (slot.wan == k[0])
                                       : (slot.queue == 2'(k - NUM_WAN));
            stat_evt[2*k] = key_hit[k] && pass_evt; // RULE13 RULE14
            stat_evt[2*k+1] = key_hit[k] && drop; // RULE13 RULE14
        end
    end

    for (genvar g = 0; g < NUM_STAT; g++) begin : g_stat
        rate_counter #(.CNT_W(32)) stat_cnt (
            .aclk(aclk),
            .aresetn(aresetn),
            .event_pulse(stat_evt[g]),
            .window_tick(win_tick),
            .rate(stat_rate[g])
        );
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_short_shaped;
        state == SLOT_FULL && ctrl[CTRL_EN_BIT] && !ctrl[CTRL_POLICE_BIT] && !fits;
    endsequence
    sequence s_short_dropped;
        state == SLOT_FULL && ctrl[CTRL_EN_BIT] && ctrl[CTRL_POLICE_BIT] && !fits
            && !ctrl[CTRL_RED_MARK_BIT];
    endsequence

    token_cap_a: assert property (tokens <= bucket_size || $changed(bucket_size)) // RULE6
        else $error("token count above bucket size");
    fill_sat_a: assert property (fill_tick && !consume && !enable_rise // RULE7
        && tok_sum >= (TOK_W+2)'(bucket_size) |=> tokens == $past(bucket_size))
        else $error("fill did not saturate at bucket size");
    send_cover_a: assert property (pass_evt && ctrl[CTRL_EN_BIT] && !mark_red // RULE8
        |-> tokens >= TOK_W'(slot.length))
        else $error("packet sent without enough tokens");
    consume_len_a: assert property (consume && !fill_tick && !enable_rise // RULE9
        |=> tokens == $past(tok_minus_len))
        else $error("tokens not reduced by packet length");
    shape_hold_a: assert property (s_short_shaped ##1 s_short_shaped // RULE11
        |-> !in_ready && !drop_pulse && $stable(slot))
        else $error("shaped packet not held");
    police_drop_a: assert property (s_short_dropped |=> drop_pulse && in_ready) // RULE12
        else $error("policed packet not dropped");
    green_mark_a: assert property (pass_evt && fits && ctrl[CTRL_EN_BIT] // RULE17
        && ctrl[CTRL_GREEN_MARK_BIT] && !out_valid |=> out_pkt.dscp == $past(green_dscp))
        else $error("green mark not applied");
    field_parse_a: assert property (out_valid // RULE1 RULE3 RULE4 RULE5
        |-> out_pkt.vlan_id == out_pkt.pkt.tci[11:0] && out_pkt.dscp == out_pkt.pkt.tos[7:2]
        && out_pkt.precedence == out_pkt.pkt.tos[7:5])
        else $error("priority fields misparsed");
    enable_fill_a: assert property ($rose(ctrl[CTRL_EN_BIT]) // RULE18
        |=> tokens == $past(bucket_size))
        else $error("bucket not full after enable");
    stat_pass_a: assert property (pass_evt // RULE13 RULE14
        |-> stat_evt[2*slot.wan] && stat_evt[2*(NUM_WAN+slot.queue)])
        else $error("pass not counted");
endmodule

// File: testbench/egress_sink.sv
// Purpose: Egress side model that accepts parsed descriptors.
// Assumes: Same clock as the meter.
// Notes: Stalls at random while slow is high, to exercise the buffer.
`timescale 1ns/1ps
module egress_sink (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic slow, // Stall at random
    output logic out_ready // Takes a descriptor
);
    int seed = 32'h3b687668;
    always @(posedge aclk) begin
        out_ready <= aresetn && (!slow || (($random(seed) & 1) != 0));
    end
endmodule

// File: testbench/token_bucket_traffic_meter_tb.sv
// Purpose: Self-checking bench for the token bucket meter.
// Assumes: Egress sink model on the output stream.
// Notes: Short rate window keeps the run brief.
`timescale 1ns/1ps
module token_bucket_traffic_meter_tb;
    import qos_meter_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic awr, wr_, bv, arr, rv, in_ready, out_valid, out_ready, drop_pulse;
    logic in_valid = 0, slow = 1;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd_;
    logic [1:0] br, rr;
    pkt_s in_pkt = '0;
    out_s out_pkt, e;
    out_s q[$];
    int seed = 32'h3b687668, fail_count = 0, n_tests = 0, cyc = 0, drops = 0, w;
    always #20 aclk = ~aclk;
    token_bucket_traffic_meter #(.RATE_WINDOW(64)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .in_valid(in_valid), .in_ready(in_ready), .in_pkt(in_pkt),
        .out_valid(out_valid), .out_ready(out_ready), .out_pkt(out_pkt),
        .drop_pulse(drop_pulse));
    egress_sink sink (.aclk(aclk), .aresetn(aresetn), .slow(slow), .out_ready(out_ready));
    task stop_test;
        if (fail_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] s);
        n_tests++;
        if (s !== x) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, x, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] xr);
        @(posedge aclk) begin
            awa <= a;
            wd <= d;
            awv <= 1;
            wv <= 1;
            bready <= 1;
        end
        do begin
            @(posedge aclk);
            if (awr) awv <= 0;
            if (wr_) wv <= 0;
        end while (bv !== 1'b1);
        bready <= 0;
        chk("bresp", {30'h0, xr}, {30'h0, br});
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] xr);
        @(posedge aclk) begin
            ara <= a;
            arv <= 1;
            rready <= 1;
        end
        do begin
            @(posedge aclk);
            if (arr) arv <= 0;
        end while (rv !== 1'b1);
        rready <= 0;
        chk("rdata", x, rd_);
        chk("rresp", {30'h0, xr}, {30'h0, rr});
    endtask
    // Kind: 0 dropped, 1 passed, 2 passed red
    task send(input logic [15:0] len, input logic [7:0] tos, input logic [1:0] k);
        pkt_s p;
        out_s x;
        p = pkt_s'(43'({$random(seed), $random(seed)}));
        p.length = len;
        p.tos = tos;
        w = 0;
        @(posedge aclk) begin
            in_pkt <= p;
            in_valid <= 1;
        end
        do begin
            @(posedge aclk);
            w++;
        end while (in_ready !== 1'b1);
        in_valid <= 0;
        // Marks chosen equal to the offered code, so rewriting leaves tos alone
        x.pkt = p;
        x.traffic = traffic_e'(p.tci[15:13]);
        x.vlan_id = p.tci[11:0];
        x.precedence = p.tos[7:5];
        x.dscp = p.tos[7:2];
        x.red = (k == 2);
        if (k != 0) q.push_back(x);
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (drop_pulse === 1'b1) drops++;
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            e = (q.size() > 0) ? q.pop_front() : 'x;
            n_tests++;
            if (out_pkt !== e) begin
                fail_count++;
                $display("MISMATCH out_pkt exp %h got %h", e, out_pkt);
            end
        end
        if (cyc > 8000) begin
            fail_count++;
            stop_test;
        end
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        rd(BUCKET_OFS, 32'h2800, 2'h0);
        rd(TOKENS_OFS, 32'h2800, 2'h0);
        rd(8'h80, 32'h0, 2'h2);
        wr(8'h80, 32'h1, 2'h2);
        repeat (4) send(16'($random(seed)), 8'($random(seed)), 1);
        slow <= 0;
        wr(FILL_AMOUNT_OFS, 0, 2'h0);
        wr(BUCKET_OFS, 100, 2'h0);
        wr(MARKS_OFS, 32'h2a15, 2'h0);
        wr(CTRL_OFS, 32'hb, 2'h0);
        rd(TOKENS_OFS, 100, 2'h0);
        send(60, 8'h56, 1);
        repeat (4) @(posedge aclk);
        rd(TOKENS_OFS, 40, 2'h0);
        send(60, 8'ha9, 0);
        repeat (4) @(posedge aclk);
        chk("drops", 1, drops);
        wr(CTRL_OFS, 32'hf, 2'h0);
        send(60, 8'ha9, 2);
        wr(CTRL_OFS, 32'h1, 2'h0);
        wr(FILL_PERIOD_OFS, 10, 2'h0);
        wr(FILL_AMOUNT_OFS, 1, 2'h0);
        repeat (1300) @(posedge aclk);
        rd(TOKENS_OFS, 100, 2'h0);
        rd(STAT_BASE_OFS + 8'h04, 32'h0, 2'h0);
        rd(STAT_BASE_OFS + 8'h14, 32'h0, 2'h0);
        send(90, 8'h56, 1);
        send(50, 8'h56, 1);
        send(1, 8'h56, 1);
        chk("held", 1, w > 300);
        repeat (40) @(posedge aclk);
        rd(STATUS_OFS, 32'h0, 2'h0);
        chk("left", 0, q.size());
        stop_test;
    end
endmodule
